/* shared/lpm_pkg.sv */
// Purpose: Constants and types for the low power mode controller
// Assumes: 250 MHz clock, classic Wishbone with 8-bit registers
// Notes:   Registers sit in the low byte of each aligned word
package lpm_pkg;

   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [4:0] PWR_CTRL_ADR = 5'h00;
   localparam logic [4:0] PWR_EXT_ADR  = 5'h04;
   localparam logic [4:0] SYS_CTRL_ADR = 5'h08;
   localparam logic [4:0] USB_CLK_ADR  = 5'h0c;
   localparam logic [4:0] USB_PWR_ADR  = 5'h10;
   localparam logic [4:0] STATUS_ADR   = 5'h14;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int DOZE_ARM_BIT    = 0;
   localparam int SLEEP_ARM_BIT   = 1;
   localparam int GEN_FLAG_LO     = 2;
   localparam int DOZE_START_BIT  = 5;
   localparam int SLEEP_START_BIT = 6;
   localparam int WAKE_SRC_BIT    = 4;
   localparam int WAKE_EN_BIT     = 7;
   localparam int BANK_SEL_BIT    = 4;
   localparam int USB_PLL_BIT     = 0;
   localparam int USB_CLK_BIT     = 1;
   localparam int RX_PD_BIT       = 0;
   localparam int IRQ0_LATCH_BIT  = 10;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic       RX_PD_RST    = 1'b1;
   localparam logic       USB_CLK_RST  = 1'b0;
   localparam logic [15:0] WAKE_VECTOR = 16'h007b;
   localparam int CLK_MHZ      = 250;
   localparam int USB_IDLE_US  = 6000;
   localparam int SUSPEND_CYC  = USB_IDLE_US * CLK_MHZ;
   localparam int SUSP_W       = 21;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LPM_RUN  = 2'b00,
      LPM_DOZE = 2'b01,
      LPM_DEEP = 2'b10
   } lpm_mode_e;

   typedef struct packed {
      logic        ale;
      logic        program_store_strobe;
      logic [7:0]  p0;
      logic        p0_oe;
      logic [7:0]  p2;
      logic [7:0]  p2_addr;
      logic [15:0] p13;
      logic [15:0] alt;
      logic [15:0] alt_sel;
      logic        ext_code;
   } lpm_pad_in_s;

   typedef struct packed {
      logic        ale;
      logic        program_store_strobe;
      logic [7:0]  p0;
      logic        p0_oe;
      logic [7:0]  p2;
      logic [15:0] p13;
   } lpm_pad_out_s;

endpackage

/* rtl/lpm_ctrl.sv */
// Purpose: Light-sleep and deep-sleep controller with Wishbone registers
// Assumes: Pins are synchronous to clk_i; rst_i is the hardware reset pin
// Notes:   Clock stop is shown by osc_run_o; clk_i itself never stops
//
// Function
// - Light-sleep gates CPU clock and watchdog; peripherals keep clock.
// - Light-sleep leaves every CPU register unchanged.
// - Light-sleep holds pin levels; active alternate functions keep driving.
// - Light-sleep drives address latch and program store strobes high.
// - Port 0 and 2 state depends on mode and internal or external code.
// - Light-sleep needs arm write alone, then start write alone.
// - Light-sleep arm and start bits self clear and read zero.
// - The start write is the last instruction before either mode.
// - Any enabled interrupt ends light-sleep.
// - Hardware reset ends light-sleep; oscillator runs so reset is quick.
// - Deep-sleep stops both oscillators; memories and registers are kept.
// - Deep-sleep drives latch values, frozen alternate values, strobes low.
// - Deep-sleep ends by reset, low wake pin, or USB activity.
// - Deep-sleep needs arm write alone, then start write alone.
// - Deep-sleep arm and start bits self clear and read zero.
// - With wake enable clear, only reset leaves deep-sleep.
// - Wake pin latch at zero on entry wakes at once.
// - USB suspends after over 6 ms idle, resumes on any activity; code ignores activity while rx_pd is set.
// - Reset out of deep-sleep restarts oscillators, resets registers.
// - Wake source select: zero picks wake pin, one picks USB.
// - Wake from deep-sleep raises wake interrupt at vector 007B.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
module lpm_ctrl #(
   parameter int SUSPEND_CYCLES = lpm_pkg::SUSPEND_CYC
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [4:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   // Core and wake sources
   input  wire logic                 irq_pending_i,
   input  wire logic                 ext_irq_zero_i,
   input  wire logic                 usb_activity_i,
   input  wire lpm_pkg::lpm_pad_in_s pad_i,
   output lpm_pkg::lpm_pad_out_s     pad_o,
   output logic                      cpu_clk_en_o,
   output logic                      wdt_clk_en_o,
   output logic                      osc_run_o,
   output logic                      usb_clk_en_o,
   output logic                      usb_pll_en_o,
   output logic                      usb_rx_pd_o,
   output logic                      usb_suspend_o,
   output logic                      wake_irq_o,
   output logic      [15:0]          wake_vec_o,
   output logic                      core_rst_o,
   output logic      [1:0]           mode_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      lpm_pkg::lpm_mode_e    mode;
      logic                  doze_armed;
      logic                  sleep_armed;
      logic [1:0]            gen_flags;
      logic                  wake_en;
      logic                  wake_usb;
      logic                  bank_sel;
      logic                  usb_clk_on;
      logic                  usb_pll_on;
      logic                  rx_pd;
      logic [7:0]            p0_hold;
      logic [7:0]            p2_hold;
      logic [15:0]           p13_hold;
      logic [lpm_pkg::SUSP_W-1:0] idle_cnt;
      logic                  suspended;
      logic                  ack;
      logic [7:0]            rdat;
      lpm_pkg::lpm_pad_out_s pad;
      logic                  cpu_clk_en;
      logic                  wdt_clk_en;
      logic                  osc_run;
      logic                  wake_irq;
      logic                  core_rst;
   } lpm_state_s;

   localparam logic [lpm_pkg::SUSP_W-1:0] SUSP_LIM =
      lpm_pkg::SUSP_W'(SUSPEND_CYCLES);

   lpm_state_s s_r;
   lpm_state_s s_nxt;

   logic       hit;
   logic       wr;
   logic [7:0] wd;
   logic [7:0] rd;
   logic       usb_seen;
   logic       pin_wake;
   logic       usb_wake;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Bus decode, register writes, mode sequencing and pad drive
   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.wake_irq = 1'b0;
      s_nxt.core_rst = 1'b0;
      hit = cyc_i & stb_i;
      wd  = dat_i[7:0];
      // Write lands on the edge where the master samples ack
      wr  = hit & s_r.ack & we_i & sel_i[0];
      s_nxt.ack = hit & ~s_r.ack;

      // Read mux; arm and start bits never read back
      // read zero
      rd = 8'h00;
      case (adr_i)
         lpm_pkg::PWR_CTRL_ADR:
            rd[lpm_pkg::GEN_FLAG_LO +: 2] = s_r.gen_flags;
         lpm_pkg::PWR_EXT_ADR:
         begin
            if (s_r.bank_sel)
            begin
               rd[lpm_pkg::WAKE_EN_BIT]  = s_r.wake_en;
               rd[lpm_pkg::WAKE_SRC_BIT] = s_r.wake_usb;
            end
         end
         lpm_pkg::SYS_CTRL_ADR:
            rd[lpm_pkg::BANK_SEL_BIT] = s_r.bank_sel;
         lpm_pkg::USB_CLK_ADR:
         begin
            rd[lpm_pkg::USB_CLK_BIT] = s_r.usb_clk_on;
            rd[lpm_pkg::USB_PLL_BIT] = s_r.usb_pll_on;
         end
         lpm_pkg::USB_PWR_ADR:
            rd[lpm_pkg::RX_PD_BIT] = s_r.rx_pd;
         lpm_pkg::STATUS_ADR:
            rd = {5'h00, s_r.suspended, s_r.mode};
         default:
            rd = 8'h00;
      endcase
      if (hit & ~s_r.ack)
      begin
         s_nxt.rdat = rd;
      end

      // Register writes other than the power control register
      if (wr)
      begin
         case (adr_i)
            lpm_pkg::PWR_EXT_ADR:
            begin
               if (s_r.bank_sel)
               begin
                  s_nxt.wake_en  = wd[lpm_pkg::WAKE_EN_BIT];
                  s_nxt.wake_usb = wd[lpm_pkg::WAKE_SRC_BIT];
               end
            end
            lpm_pkg::SYS_CTRL_ADR:
               s_nxt.bank_sel = wd[lpm_pkg::BANK_SEL_BIT];
            lpm_pkg::USB_CLK_ADR:
            begin
               s_nxt.usb_clk_on = wd[lpm_pkg::USB_CLK_BIT];
               s_nxt.usb_pll_on = wd[lpm_pkg::USB_PLL_BIT];
            end
            lpm_pkg::USB_PWR_ADR:
               s_nxt.rx_pd = wd[lpm_pkg::RX_PD_BIT];
            default:
               s_nxt.rx_pd = s_r.rx_pd;
         endcase
      end

      // Power control: arm must be a lone write, start the very next one.
      // Any other write to this register disarms, so a stray store cannot
      // complete the pair later.
      if (wr && adr_i == lpm_pkg::PWR_CTRL_ADR)
      begin
         s_nxt.gen_flags   = wd[lpm_pkg::GEN_FLAG_LO +: 2];
         s_nxt.doze_armed  = 1'b0;
         s_nxt.sleep_armed = 1'b0;
         if (wd[lpm_pkg::DOZE_ARM_BIT] & ~wd[lpm_pkg::DOZE_START_BIT])
         begin
            s_nxt.doze_armed = 1'b1;
         end
         if (wd[lpm_pkg::SLEEP_ARM_BIT] & ~wd[lpm_pkg::SLEEP_START_BIT])
         begin
            s_nxt.sleep_armed = 1'b1;
         end
         if (s_r.mode == lpm_pkg::LPM_RUN)
         begin
            if (s_r.doze_armed & wd[lpm_pkg::DOZE_START_BIT] &
                ~wd[lpm_pkg::DOZE_ARM_BIT])
            begin
               s_nxt.mode     = lpm_pkg::LPM_DOZE;
               s_nxt.p0_hold  = s_r.pad.p0;
               s_nxt.p2_hold  = s_r.pad.p2;
               s_nxt.p13_hold = s_r.pad.p13;
            end
            else if (s_r.sleep_armed & wd[lpm_pkg::SLEEP_START_BIT] &
                     ~wd[lpm_pkg::SLEEP_ARM_BIT])
            begin
               s_nxt.mode = lpm_pkg::LPM_DEEP;
               s_nxt.p13_hold = pad_i.alt;
            end
         end
      end

      // USB suspend: activity is seen only while the receiver is powered
      // suspend after idle
      usb_seen = usb_activity_i & ~s_r.rx_pd;
      usb_wake = 1'b0;
      if (usb_seen)
      begin
         s_nxt.idle_cnt  = '0;
         s_nxt.suspended = 1'b0;
         usb_wake        = s_r.suspended;
      end
      else if (s_r.idle_cnt == SUSP_LIM)
      begin
         s_nxt.suspended = 1'b1;
      end
      else
      begin
         s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
      end

      // Wake pin is low when the pin or its own port latch pulls low
      // latch zero wakes
      pin_wake = ~(ext_irq_zero_i & pad_i.p13[lpm_pkg::IRQ0_LATCH_BIT]);

      // Leaving the modes
      case (s_r.mode)
         lpm_pkg::LPM_DOZE:
         begin
            if (irq_pending_i)
            begin
               s_nxt.mode = lpm_pkg::LPM_RUN;
            end
         end
         lpm_pkg::LPM_DEEP:
         begin
            if (s_r.wake_en &&
                (s_r.wake_usb ? usb_wake : pin_wake))
            begin
               s_nxt.mode = lpm_pkg::LPM_RUN;
               s_nxt.wake_irq = 1'b1;
            end
         end
         default:
            s_nxt.mode = s_nxt.mode;
      endcase

      // Clock gating follows the coming mode
      // CPU and watchdog gated
      s_nxt.cpu_clk_en = (s_nxt.mode == lpm_pkg::LPM_RUN);
      s_nxt.wdt_clk_en = (s_nxt.mode == lpm_pkg::LPM_RUN);
      s_nxt.osc_run    = (s_nxt.mode != lpm_pkg::LPM_DEEP);

      // Pad drive per mode
      case (s_nxt.mode)
         lpm_pkg::LPM_DOZE:
         begin
            s_nxt.pad.ale   = 1'b1;
            s_nxt.pad.program_store_strobe  = 1'b1;
            // port 0 float on external code
            s_nxt.pad.p0    = s_nxt.p0_hold;
            s_nxt.pad.p0_oe = ~pad_i.ext_code;
            // Holds data, or the address out at entry
            s_nxt.pad.p2    = s_nxt.p2_hold;
            s_nxt.pad.p13   = (pad_i.alt_sel & pad_i.alt) |
                              (~pad_i.alt_sel & s_nxt.p13_hold);
         end
         lpm_pkg::LPM_DEEP:
         begin
            s_nxt.pad.ale   = 1'b0;
            s_nxt.pad.program_store_strobe  = 1'b0;
            s_nxt.pad.p0    = pad_i.p0;
            s_nxt.pad.p0_oe = ~pad_i.ext_code;
            s_nxt.pad.p2    = pad_i.p2;
            s_nxt.pad.p13   = (pad_i.alt_sel & s_nxt.p13_hold) |
                              (~pad_i.alt_sel & pad_i.p13);
         end
         default:
         begin
            s_nxt.pad.ale   = pad_i.ale;
            s_nxt.pad.program_store_strobe  = pad_i.program_store_strobe;
            s_nxt.pad.p0    = pad_i.p0;
            s_nxt.pad.p0_oe = pad_i.p0_oe;
            s_nxt.pad.p2    = pad_i.ext_code ? pad_i.p2_addr : pad_i.p2;
            s_nxt.pad.p13   = (pad_i.alt_sel & pad_i.alt) |
                              (~pad_i.alt_sel & pad_i.p13);
         end
      endcase

      // Hardware reset wins over every mode. The oscillator runs in
      // light-sleep, so one clock suffices; after deep-sleep the pin
      // must be held until the oscillator settles, outside this block.
      // reset exit
      if (rst_i)
      begin
         s_nxt            = '0;
         s_nxt.mode       = lpm_pkg::LPM_RUN;
         s_nxt.rx_pd      = lpm_pkg::RX_PD_RST;
         s_nxt.usb_clk_on = lpm_pkg::USB_CLK_RST;
         s_nxt.cpu_clk_en = 1'b1;
         s_nxt.wdt_clk_en = 1'b1;
         s_nxt.osc_run    = 1'b1;
         s_nxt.core_rst   = 1'b1;
         s_nxt.pad.ale    = 1'b1;
         s_nxt.pad.program_store_strobe   = 1'b1;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Reset is folded into the next-state logic above
   always_ff @(posedge clk_i)
   begin
      s_r <= s_nxt;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // All straight from state flops except the constant wake vector; USB clocks die with the oscillator
   assign dat_o         = {24'h000000, s_r.rdat};
   assign ack_o         = s_r.ack;
   assign pad_o         = s_r.pad;
   assign cpu_clk_en_o  = s_r.cpu_clk_en;
   assign wdt_clk_en_o  = s_r.wdt_clk_en;
   assign osc_run_o     = s_r.osc_run;
   assign usb_clk_en_o  = s_r.usb_clk_on;
   assign usb_pll_en_o  = s_r.usb_pll_on;
   assign usb_rx_pd_o   = s_r.rx_pd;
   assign usb_suspend_o = s_r.suspended;
   assign wake_irq_o    = s_r.wake_irq;
   assign wake_vec_o    = lpm_pkg::WAKE_VECTOR;
   assign core_rst_o    = s_r.core_rst;
   assign mode_o        = s_r.mode;

endmodule // lpm_ctrl

/* test/lpm_ctrl_sva.sv */
// Purpose: Port checker for the low power mode controller
// Assumes: One clock, rst_i synchronous and active high
// Notes:   Mode codes 00 run, 01 light-sleep, 10 deep-sleep
`timescale 1ns/100ps
module lpm_ctrl_sva (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  we_i,
   input wire logic [4:0]            adr_i,
   input wire logic [31:0]           dat_o,
   input wire logic                  ack_o,
   input wire logic                  irq_pending_i,
   input wire logic                  ext_irq_zero_i,
   input wire logic                  usb_activity_i,
   input wire lpm_pkg::lpm_pad_in_s  pad_i,
   input wire lpm_pkg::lpm_pad_out_s pad_o,
   input wire logic                  cpu_clk_en_o,
   input wire logic                  wdt_clk_en_o,
   input wire logic                  osc_run_o,
   input wire logic                  wake_irq_o,
   input wire logic [15:0]           wake_vec_o,
   input wire logic                  core_rst_o,
   input wire logic [1:0]            mode_o
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack; ack_o |=> !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");

   property p_doze_clk;
      mode_o == 2'b01 |-> !cpu_clk_en_o && !wdt_clk_en_o && osc_run_o;
   endproperty
   a_doze_clk: assert property (p_doze_clk)
      else $error("light-sleep clock enables wrong");

   // Pins frozen and strobes high once light-sleep has settled
   property p_doze_pins;
      mode_o == 2'b01 && $past(mode_o) == 2'b01 && $past(mode_o, 2) == 2'b01
      |-> pad_o.ale && pad_o.program_store_strobe && $stable(pad_o.p0) && $stable(pad_o.p2);
   endproperty
   a_doze_pins: assert property (p_doze_pins)
      else $error("light-sleep pins not held");

   property p_deep;
      mode_o == 2'b10 && $past(mode_o) == 2'b10 |-> !osc_run_o
      && !pad_o.ale && !pad_o.program_store_strobe && pad_o.p0 == $past(pad_i.p0);
   endproperty
   a_deep: assert property (p_deep)
      else $error("deep-sleep pins or oscillator wrong");

   property p_doze_exit; mode_o == 2'b01 && irq_pending_i |=> mode_o == 2'b00;
   endproperty
   a_doze_exit: assert property (p_doze_exit)
      else $error("interrupt did not end light-sleep");

   // No wake source active means deep-sleep must persist
   property p_deep_stay;
      mode_o == 2'b10 && ext_irq_zero_i && !usb_activity_i && pad_i.p13[10]
      |=> mode_o == 2'b10;
   endproperty
   a_deep_stay: assert property (p_deep_stay)
      else $error("deep-sleep left without cause");

   property p_wake;
      wake_irq_o |-> wake_vec_o == 16'h007b && mode_o == 2'b00
      && $past(mode_o) == 2'b10;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake interrupt wrong");

   property p_rst;
      $fell(rst_i) |-> mode_o == 2'b00 && core_rst_o && cpu_clk_en_o
      && osc_run_o;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset did not restore run mode");

   property p_rd0;
      ack_o && !we_i && adr_i == 5'h00 |-> dat_o[1:0] == 2'b00
      && dat_o[6:5] == 2'b00 && dat_o[31:8] == 24'h0;
   endproperty
   a_rd0: assert property (p_rd0)
      else $error("arm or start bit read nonzero");

   // Sleep begins at the edge where a power control write is acknowledged
   property p_entry;
      mode_o != 2'b00 && $past(mode_o) == 2'b00
      |-> $past(ack_o) && $past(we_i) && $past(adr_i) == 5'h00;
   endproperty
   a_entry: assert property (p_entry)
      else $error("sleep entered without a write");
endmodule // lpm_ctrl_sva

bind lpm_ctrl lpm_ctrl_sva i_sva (.clk_i, .rst_i, .we_i, .adr_i, .dat_o,
   .ack_o, .irq_pending_i, .ext_irq_zero_i, .usb_activity_i, .pad_i, .pad_o,
   .cpu_clk_en_o, .wdt_clk_en_o, .osc_run_o, .wake_irq_o, .wake_vec_o,
   .core_rst_o, .mode_o);

/* test/lpm_wake_src.sv */
// Purpose: Wake pin and USB bus activity source
// Assumes: Requests arrive synchronous to clk_i
// Notes:   Pin idles high through its pull-up
`timescale 1ns/100ps
module lpm_wake_src (
   input  wire logic clk_i,
   input  wire logic pin_req_i,
   input  wire logic usb_req_i,
   output logic      ext_irq_zero_o,
   output logic      usb_activity_o
);
   logic [3:0] pin_cnt_r = 4'h0;
   logic [3:0] usb_cnt_r = 4'h0;
   // Pin held low long enough to latch; bus shows a toggling burst
   // wake sources
   always_ff @(posedge clk_i)
   begin
      pin_cnt_r <= pin_req_i ? 4'h8 : pin_cnt_r - (pin_cnt_r != 4'h0);
      usb_cnt_r <= usb_req_i ? 4'h9 : usb_cnt_r - (usb_cnt_r != 4'h0);
   end
   assign ext_irq_zero_o = (pin_cnt_r == 4'h0);
   assign usb_activity_o = usb_cnt_r[0];
endmodule // lpm_wake_src

/* test/testbench.sv */
// Purpose: Self-checking bench for the low power mode controller
// Assumes: Short suspend count so the idle timeout is reached quickly
// Notes:   Pads are randomised from a fixed xorshift seed
`timescale 1ns/100ps
module testbench;
   localparam int SUS = 20;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
   logic we_i = 1'b0, irq_pending_i = 1'b0, pin_req = 1'b0;
   logic usb_req = 1'b0, lat = 1'b1, ack_o, wake_irq_o, cpu_clk_en_o;
   logic osc_run_o, usb_suspend_o, ext_irq_zero_i, usb_activity_i;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h1;
   logic [31:0] dat_i = 32'h0, dat_o, seed = 32'h0000ce06;
   logic [1:0] mode_o, m;
   logic [7:0] q;
   logic [18:0] v, po;
   logic [15:0] v13, va;
   logic [2:0] uo;
   lpm_pkg::lpm_pad_in_s pad_i = '0;
   lpm_pkg::lpm_pad_out_s pad_o;
   int error_cnt = 0, n_compared = 0;
   logic [7:0] ta [7] = '{8'h01, 8'h21, 8'h01, 8'h02, 8'h42, 8'h01, 8'h02};
   logic [7:0] tb2 [7] = '{8'h20, 8'h20, 8'h21, 8'h40, 8'h40, 8'h40, 8'h0c};
   assign po = {pad_o.ale, pad_o.program_store_strobe, pad_o.p0, pad_o.p0_oe, pad_o.p2};

   lpm_ctrl #(.SUSPEND_CYCLES(SUS)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_pending_i,
      .ext_irq_zero_i, .usb_activity_i, .pad_i, .pad_o, .cpu_clk_en_o,
      .wdt_clk_en_o(), .osc_run_o, .usb_clk_en_o(uo[2]),
      .usb_pll_en_o(uo[1]), .usb_rx_pd_o(uo[0]), .usb_suspend_o,
      .wake_irq_o, .wake_vec_o(),
      .core_rst_o(), .mode_o);
   lpm_wake_src i_src (.clk_i, .pin_req_i(pin_req), .usb_req_i(usb_req),
      .ext_irq_zero_o(ext_irq_zero_i), .usb_activity_o(usb_activity_i));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [1:0] seq_mode(input logic [7:0] a, b);
      if (a[0] && !a[5] && b[5] && !b[0]) return 2'b01;
      if (a[1] && !a[6] && b[6] && !b[1]) return 2'b10;
      return 2'b00;
   endfunction

   // Light-sleep holds the pins seen at entry, v
   function automatic logic [18:0] exp_pads(input logic [1:0] md,
      input lpm_pkg::lpm_pad_in_s p, input logic [18:0] h);
      if (md == 2'b01) return {2'b11, h[16:9], !p.ext_code, h[7:0]};
      if (md == 2'b10) return {2'b00, p.p0, !p.ext_code, p.p2};
      return {p.ale, p.program_store_strobe, p.p0, p.p0_oe, p.ext_code ? p.p2_addr : p.p2};
   endfunction

   // Port 1 and 3: live alternates, held latches, or frozen alternates
   function automatic logic [15:0] exp_p13(input logic [1:0] md,
      input lpm_pkg::lpm_pad_in_s p, input logic [15:0] h, a);
      if (md == 2'b10) return (p.alt_sel & a) | (~p.alt_sel & p.p13);
      return (p.alt_sel & p.alt) | (~p.alt_sel & (md == 2'b01 ? h : p.p13));
   endfunction

   task automatic chk(input string nm, input logic [18:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rnd_pads;
      lpm_pkg::lpm_pad_in_s p;
      seed = xs(seed);
      p = {xs(seed), seed, seed[23:12]};
      p.p13[10] = lat;
      pad_i <= p;
   endtask

   // Holds the request until ack is sampled, then idles one cycle
   task automatic wb(input logic w, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 40)
      begin
         @(posedge clk_i);
         n++;
      end
      r = dat_o[7:0];
      {cyc_i, stb_i} <= 2'b00;
      @(posedge clk_i);
      if (n == 40) chk("ack", 1, 0);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00, q);
      chk(nm, e, q);
   endtask

   task automatic wait_wake(input string nm);
      int n;
      n = 0;
      while (wake_irq_o !== 1'b1 && n < 30)
      begin
         @(posedge clk_i);
         n++;
      end
      chk(nm, 1, wake_irq_o);
   endtask

   task automatic wake_cfg(input logic [7:0] d);
      wr(lpm_pkg::SYS_CTRL_ADR, 8'h10);
      wr(lpm_pkg::PWR_EXT_ADR, d);
      rd("ext_on", lpm_pkg::PWR_EXT_ADR, d);
      wr(lpm_pkg::SYS_CTRL_ADR, 8'h00);
      rd("ext_off", lpm_pkg::PWR_EXT_ADR, 8'h00);
   endtask

   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #80000;
      error_cnt++;
      end_sim;
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd("rx_pd_rst", lpm_pkg::USB_PWR_ADR, 8'h01);
      rd("unmapped", 5'h1c, 8'h00);
      wr(lpm_pkg::USB_CLK_ADR, 8'h03);
      chk("usb_on", 3'b111, uo);
      wr(lpm_pkg::USB_CLK_ADR, 8'h00);
      chk("usb_off", 3'b001, uo);
      wake_cfg(8'h80);
      $display("test setup done");
      for (int i = 0; i < 7; i++)
      begin
         m = seq_mode(ta[i], tb2[i]);
         rnd_pads();
         repeat (2) @(posedge clk_i);
         v = po;
         v13 = pad_o.p13;
         va = pad_i.alt;
         wr(lpm_pkg::PWR_CTRL_ADR, ta[i]);
         wr(lpm_pkg::PWR_CTRL_ADR, tb2[i]);
         @(posedge clk_i);
         chk("mode", m, mode_o);
         chk("cpu_clk", m == 2'b00, cpu_clk_en_o);
         chk("osc", m != 2'b10, osc_run_o);
         rnd_pads();
         repeat (2) @(posedge clk_i);
         chk("pads", exp_pads(m, pad_i, v), po);
         chk("p13", exp_p13(m, pad_i, v13, va), pad_o.p13);
         irq_pending_i <= (m == 2'b01);
         pin_req <= (m == 2'b10);
         @(posedge clk_i);
         {irq_pending_i, pin_req} <= 2'b00;
         if (m == 2'b10) wait_wake("pin_wake");
         repeat (2) @(posedge clk_i);
         chk("mode_exit", 0, mode_o);
         rd("pwr_rd", lpm_pkg::PWR_CTRL_ADR, tb2[i] & 8'h0c);
      end
      $display("test entry table done");
      wake_cfg(8'h00);
      wr(lpm_pkg::PWR_CTRL_ADR, 8'h02);
      wr(lpm_pkg::PWR_CTRL_ADR, 8'h40);
      pin_req <= 1'b1;
      @(posedge clk_i);
      pin_req <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk("no_wake", 2'b10, mode_o);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("rst_mode", 0, mode_o);
      rd("pwr_rst", lpm_pkg::PWR_CTRL_ADR, 8'h00);
      $display("test reset exit done");
      wake_cfg(8'h80);
      lat = 1'b0;
      rnd_pads();
      wr(lpm_pkg::PWR_CTRL_ADR, 8'h02);
      wr(lpm_pkg::PWR_CTRL_ADR, 8'h40);
      wait_wake("latch_wake");
      lat = 1'b1;
      rnd_pads();
      $display("test latch wake done");
      wake_cfg(8'h90);
      wr(lpm_pkg::USB_PWR_ADR, 8'h00);
      chk("rx_on", 3'b000, uo);
      usb_req <= 1'b1;
      @(posedge clk_i);
      usb_req <= 1'b0;
      // Last burst pulse is sampled 9 edges on; suspend needs SUS + 1 idle
      repeat (SUS + 10) @(posedge clk_i);
      chk("not_susp", 0, usb_suspend_o);
      @(posedge clk_i);
      chk("susp", 1, usb_suspend_o);
      rd("status", lpm_pkg::STATUS_ADR, 8'h04);
      wr(lpm_pkg::PWR_CTRL_ADR, 8'h02);
      wr(lpm_pkg::PWR_CTRL_ADR, 8'h40);
      pin_req <= 1'b1;
      @(posedge clk_i);
      pin_req <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk("src_usb", 2'b10, mode_o);
      usb_req <= 1'b1;
      @(posedge clk_i);
      usb_req <= 1'b0;
      wait_wake("usb_wake");
      repeat (2) @(posedge clk_i);
      chk("resume", 0, usb_suspend_o);
      $display("test usb wake done");
      end_sim;
   end
endmodule // testbench
